// ---- src/jmp_pkg.sv ----
//----------------------------------------------------------------------
// Purpose: Shared constants and types for the link mode and alignment
//          parameter block.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Register offsets are byte addresses.
//----------------------------------------------------------------------
package jmp_pkg;

  //--------------------------------------------------------------------
  // Register map
  //--------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_KCOUNT = 8'h04;
  localparam logic [7:0] OFS_DEVID  = 8'h08;
  localparam logic [7:0] OFS_CFGSEL = 8'h0C;
  localparam logic [7:0] OFS_PARAMS = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields.
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_SCR_BIT   = 5;
  localparam int CTRL_INSEL_LSB = 6;
  localparam int CTRL_EN_BIT    = 8;
  // Selection register fields.
  localparam int SEL_LANE_LSB   = 0;
  localparam int SEL_OCT_LSB    = 4;

  //--------------------------------------------------------------------
  // Reset values and encodings
  //--------------------------------------------------------------------
  localparam logic [4:0] RST_MODE  = 5'h00;
  localparam logic [7:0] RST_KM1   = 8'h1F;
  localparam logic [7:0] RST_DID   = 8'h00;
  localparam logic [1:0] INSEL_A    = 2'h0;
  localparam logic [1:0] INSEL_B    = 2'h1;
  localparam logic [1:0] INSEL_BOTH = 2'h2;

  localparam logic [2:0] JESDV_VAL    = 3'h1;
  localparam logic [2:0] SUBCLASS_VAL = 3'h1;
  localparam logic       EXTMB_VAL    = 1'h1;
  localparam logic [7:0] ZERO_FIELD   = 8'h00;
  localparam logic [3:0] CFG_OCTETS   = 4'hE;
  localparam logic [3:0] MULTIFRAMES_IN_ILAS = 4'h4;

  //--------------------------------------------------------------------
  // Types
  //--------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       enc64;
    logic       des;
    logic [1:0] links;
    logic [3:0] lanes;
    logic [3:0] conv;
    logic [3:0] octets;
    logic [3:0] samples;
    logic [4:0] res;
    logic [4:0] resTot;
    logic [1:0] ctlBits;
    logic       hd;
    logic [7:0] rateX8;
    logic [5:0] kMin;
    logic [4:0] kStep;
  } jmp_mode_s;

  typedef enum logic [3:0] {
    LINK_OFF  = 4'h1,
    LINK_CGS  = 4'h2,
    LINK_ILAS = 4'h4,
    LINK_DATA = 4'h8
  } jmp_link_e;

endpackage

// ---- src/jmp_ilas_cfg.sv ----
//----------------------------------------------------------------------
// Purpose: Builds the alignment configuration octets and checksum.
// Assumes: User fields arrive as sent; mode counts are reduced by one here.
// Notes:   Purely combinational; the caller registers the result.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module jmp_ilas_cfg
  import jmp_pkg::*;
(
  // Derived link parameters
  input  wire jmp_mode_s  mode,
  // User fields
  input  wire logic [7:0] devId,
  input  wire logic [4:0] laneId,
  input  wire logic       scramble,
  input  wire logic [7:0] kMinusOne,
  // Octet selection
  input  wire logic [3:0] octSel,
  output logic      [7:0] octet,
  output logic      [7:0] checksum
);

  logic [7:0] lm1, fm1, mm1, nm1, npm1, sm1;

  always_comb begin
    lm1  = {4'h0, mode.lanes - 4'h1};
    fm1  = {4'h0, mode.octets - 4'h1};
    mm1  = {4'h0, mode.conv - 4'h1};
    nm1  = {3'h0, mode.res - 5'h01};
    npm1 = {3'h0, mode.resTot - 5'h01};
    sm1  = {4'h0, mode.samples - 4'h1};
    // The modulo-256 wrap comes free from the 8-bit sum. [RULE16]
    checksum = devId + ZERO_FIELD + ZERO_FIELD + {3'h0, laneId}
             + ZERO_FIELD + lm1 + {7'h00, scramble} + fm1 + kMinusOne
             + mm1 + nm1 + ZERO_FIELD + npm1 + {5'h00, SUBCLASS_VAL}
             + sm1 + {5'h00, JESDV_VAL} + ZERO_FIELD + ZERO_FIELD
             + ZERO_FIELD + ZERO_FIELD;
    case (octSel)
      4'h0: octet = devId; // [RULE12]
      4'h1: octet = ZERO_FIELD; // [RULE10]
      4'h2: octet = {3'h0, laneId}; // [RULE17]
      4'h3: octet = {scramble, 2'h0, lm1[4:0]}; // [RULE15]
      4'h4: octet = fm1;
      4'h5: octet = kMinusOne;
      4'h6: octet = mm1;
      4'h7: octet = {2'h0, 1'h0, nm1[4:0]}; // [RULE11]
      4'h8: octet = {SUBCLASS_VAL, npm1[4:0]}; // [RULE14]
      4'h9: octet = {JESDV_VAL, sm1[4:0]}; // [RULE14]
      4'hA: octet = {1'h0, 7'h00}; // [RULE13] [RULE10]
      4'hB: octet = ZERO_FIELD; // [RULE10]
      4'hC: octet = ZERO_FIELD; // [RULE10]
      4'hD: octet = checksum; // [RULE16]
      default: octet = 8'h00;
    endcase
  end

endmodule

// ---- src/jmp_mode_ctrl.sv ----
//----------------------------------------------------------------------
// Purpose: Link mode selection, parameter derivation and alignment
//          sequencing for the converter's serial transmitter.
// Assumes: sys_clk is the device clock; syncReqN comes from the pin.
// Notes:   One frame per clock is assumed for the alignment count.
//----------------------------------------------------------------------
// How it works
// [RULE1] Interleaved dual-input: channels sample in opposite phases, rate doubles.
// [RULE2] Dual-input mode needs a single-channel mode plus both inputs selected.
// [RULE3] Dual-input mode keeps the single-channel digital and link behaviour.
// [RULE4] The link mode selector alone fixes every derived link parameter.
// [RULE5] Interleave flag is 1 for single-channel modes, 0 for dual.
// [RULE6] Lane bit factor times clock gives lane rate and serializer setting.
// [RULE7] Frame count comes from software, used only in 8B/10B modes.
// [RULE8] Multiblocks per extended multiblock is 1, ignored in 8B/10B.
// [RULE9] Alignment sequence with parameters only in 8B/10B modes.
// [RULE10] Adjust count, direction, bank, control words, reserved fields sent 0.
// [RULE11] Control bits per sample are reported as 0 in the sequence.
// [RULE12] Device identifier comes from a software register.
// [RULE13] High-density flag is always sent as 0.
// [RULE14] Standard revision and subclass version are both sent as 1.
// [RULE15] Scrambler field and lane scrambling follow a software bit.
// [RULE16] Checksum is the sum of the other fields modulo 256.
// [RULE17] Each lane carries its own lane identifier.
// [RULE18] Octets, lanes, converters, resolution, bits and samples from mode.
// [RULE19] Sync request starts code group sync then alignment sequence.
// [RULE20] Frame count field holds count minus one; one is added.
//----------------------------------------------------------------------
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
module jmp_mode_ctrl
  import jmp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receiver sync request pin
  input  wire logic        syncReqN,
  // Sampling control
  output logic             desMode,
  output logic             dualInputMode,
  output logic             chBPhaseInverted,
  output logic             analogInputAEn,
  output logic             analogInputBEn,
  output logic [1:0]       sampleRateFactor,
  // Serializer and link control
  output logic [7:0]       laneRateX8,
  output logic [3:0]       lanesPerLink,
  output logic             scramblerEn,
  output logic             extMultiblocks,
  output logic             sendCgs,
  output logic             sendIlas,
  output logic             sendData
);

  //--------------------------------------------------------------------
  // Mode table
  //--------------------------------------------------------------------
  function automatic jmp_mode_s mk(
    input logic des, input logic [3:0] l, input logic [3:0] m,
    input logic [3:0] f, input logic [3:0] s, input logic [4:0] n,
    input logic [4:0] np, input logic [1:0] cs, input logic hd,
    input logic [7:0] r8, input logic [5:0] kmin, input logic [4:0] kst);
    jmp_mode_s p;
    p = '{valid: 1'b1, enc64: 1'b0, des: des, links: 2'h2, lanes: l,
          conv: m, octets: f, samples: s, res: n, resTot: np,
          ctlBits: cs, hd: hd, rateX8: r8, kMin: kmin, kStep: kst};
    return p;
  endfunction

  // Lane bit factor is held as eight times R so fractional R stays exact.
  function automatic jmp_mode_s modeLookup(input logic [4:0] sel);
    jmp_mode_s p;
    p = '0;
    case (sel) // [RULE4] [RULE18] [RULE5] [RULE6]
      5'h00: p = mk(1'b1,4'h4,4'h4,4'h8,4'h5,5'h0C,5'h0C,2'h0,1'b0,
                    8'h20,6'h04,5'h02);
      5'h01: p = mk(1'b1,4'h8,4'h8,4'h8,4'h5,5'h0C,5'h0C,2'h0,1'b0,
                    8'h10,6'h04,5'h02);
      5'h02: p = mk(1'b0,4'h4,4'h4,4'h8,4'h5,5'h0C,5'h0C,2'h0,1'b0,
                    8'h20,6'h04,5'h02);
      5'h03: p = mk(1'b0,4'h8,4'h8,4'h8,4'h5,5'h0C,5'h0C,2'h0,1'b0,
                    8'h10,6'h04,5'h02);
      5'h05: p = mk(1'b1,4'h4,4'h1,4'h1,4'h4,5'h08,5'h08,2'h0,1'b0,
                    8'h14,6'h20,5'h10);
      5'h06: p = mk(1'b1,4'h8,4'h1,4'h1,4'h8,5'h08,5'h08,2'h0,1'b0,
                    8'h0A,6'h20,5'h10);
      5'h07: p = mk(1'b0,4'h4,4'h1,4'h1,4'h4,5'h08,5'h08,2'h0,1'b0,
                    8'h14,6'h20,5'h10);
      5'h08: p = mk(1'b0,4'h8,4'h1,4'h1,4'h8,5'h08,5'h08,2'h0,1'b0,
                    8'h0A,6'h20,5'h10);
      5'h0A: p = mk(1'b0,4'h2,4'h2,4'h2,4'h1,5'h0F,5'h10,2'h1,1'b0,
                    8'h28,6'h10,5'h08);
      5'h0B: p = mk(1'b0,4'h4,4'h2,4'h2,4'h2,5'h0F,5'h10,2'h1,1'b0,
                    8'h14,6'h10,5'h08);
      5'h0C: p = mk(1'b0,4'h8,4'h2,4'h2,4'h4,5'h0F,5'h10,2'h1,1'b0,
                    8'h0A,6'h10,5'h08);
      5'h0D: p = mk(1'b0,4'h1,4'h2,4'h4,4'h1,5'h0F,5'h10,2'h1,1'b0,
                    8'h28,6'h08,5'h04);
      5'h0E: p = mk(1'b0,4'h2,4'h2,4'h2,4'h1,5'h0F,5'h10,2'h1,1'b0,
                    8'h14,6'h10,5'h08);
      5'h0F: p = mk(1'b0,4'h4,4'h2,4'h2,4'h2,5'h0F,5'h10,2'h1,1'b0,
                    8'h0A,6'h10,5'h08);
      5'h10: p = mk(1'b0,4'h8,4'h2,4'h2,4'h4,5'h0F,5'h10,2'h1,1'b0,
                    8'h05,6'h10,5'h08);
      5'h13: p = mk(1'b1,4'h6,4'h1,4'h2,4'h8,5'h0C,5'h0C,2'h0,1'b1,
                    8'h14,6'h10,5'h08);
      5'h14: p = mk(1'b0,4'h6,4'h1,4'h2,4'h8,5'h0C,5'h0C,2'h0,1'b1,
                    8'h14,6'h10,5'h08);
      5'h15: p = mk(1'b1,4'h2,4'h1,4'h2,4'h2,5'h0F,5'h10,2'h1,1'b0,
                    8'h28,6'h10,5'h08);
      5'h16: p = mk(1'b1,4'h4,4'h1,4'h2,4'h4,5'h0F,5'h10,2'h1,1'b0,
                    8'h14,6'h10,5'h08);
      5'h17: p = mk(1'b1,4'h1,4'h1,4'h2,4'h1,5'h0F,5'h10,2'h1,1'b0,
                    8'h28,6'h10,5'h08);
      5'h18: p = mk(1'b1,4'h2,4'h1,4'h2,4'h2,5'h0F,5'h10,2'h1,1'b0,
                    8'h14,6'h10,5'h08);
      5'h19: p = mk(1'b1,4'h8,4'h1,4'h2,4'h8,5'h0F,5'h10,2'h1,1'b0,
                    8'h0A,6'h10,5'h08);
      5'h1A: p = mk(1'b1,4'h4,4'h1,4'h2,4'h4,5'h0F,5'h10,2'h1,1'b0,
                    8'h0A,6'h10,5'h08);
      default: p = '0;
    endcase
    return p;
  endfunction

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  mode;
    logic        scr;
    logic [1:0]  inSel;
    logic        linkEn;
    logic [7:0]  km1;
    logic [7:0]  did;
    logic [3:0]  laneSel;
    logic [3:0]  octSel;
    logic        syncMeta;
    logic        syncLvl;
    jmp_link_e   link;
    logic [10:0] ilasCnt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        des;
    logic        dualIn;
    logic        chBInv;
    logic        inAEn;
    logic        inBEn;
    logic [1:0]  rateFac;
    logic [7:0]  rateX8;
    logic [3:0]  lanes;
    logic        scrEn;
    logic        extMb;
    logic        cgs;
    logic        ilas;
    logic        data;
  } jmp_state_s;

  jmp_state_s st;
  jmp_state_s next_st;
  jmp_mode_s  p;
  logic [8:0] kFrames;
  logic [7:0] kSent;
  logic       kOk;
  logic [10:0] ilasLast;
  logic [7:0] cfgOctet;
  logic [7:0] cfgSum;
  logic       wrEn;
  logic       rdPhase;

  //--------------------------------------------------------------------
  // Alignment configuration data
  //--------------------------------------------------------------------
  jmp_ilas_cfg u_cfg (
    .mode      (p),
    .devId     (st.did),
    .laneId    ({1'b0, st.laneSel}),
    .scramble  (st.scr),
    .kMinusOne (kSent),
    .octSel    (st.octSel),
    .octet     (cfgOctet),
    .checksum  (cfgSum)
  );

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    next_st = st;
    p       = modeLookup(st.mode); // [RULE4]
    kFrames = {1'b0, st.km1} + 9'h001; // [RULE20]
    // The frame count only matters on 8B/10B links. [RULE7]
    kSent   = p.enc64 ? 8'h00 : st.km1;
    kOk     = p.enc64 || ((kFrames >= {3'h0, p.kMin}) &&
              ((kFrames & ({4'h0, p.kStep} - 9'h001)) == 9'h000));
    ilasLast = {kFrames, 2'h0} - 11'h001;
    wrEn    = psel && penable && st.pready && pwrite;
    rdPhase = psel && !penable;

    // Register access; the answer is ready one cycle after setup.
    next_st.pready = rdPhase;
    if (rdPhase) begin
      next_st.pslverr = 1'b0;
      case (paddr)
        OFS_CTRL:   next_st.prdata = {23'h0, st.linkEn, st.inSel,
                                      st.scr, st.mode};
        OFS_KCOUNT: next_st.prdata = {24'h0, st.km1};
        OFS_DEVID:  next_st.prdata = {24'h0, st.did};
        OFS_CFGSEL: next_st.prdata = {24'h0, st.octSel, st.laneSel};
        OFS_PARAMS: next_st.prdata = {p.valid, p.enc64, p.des,
                                      p.links, p.lanes, p.conv,
                                      p.octets, p.samples, p.res,
                                      p.ctlBits, p.hd, 3'h0}; // [RULE18]
        OFS_STATUS: next_st.prdata = {kFrames, 1'b0, st.link, kOk,
                                      1'b0, cfgSum, cfgOctet};
        default: begin
          next_st.prdata  = 32'h0;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (wrEn) begin
      case (paddr)
        OFS_CTRL: begin
          next_st.mode   = pwdata[CTRL_MODE_LSB +: 5];
          next_st.scr    = pwdata[CTRL_SCR_BIT]; // [RULE15]
          next_st.inSel  = pwdata[CTRL_INSEL_LSB +: 2];
          next_st.linkEn = pwdata[CTRL_EN_BIT];
        end
        OFS_KCOUNT: next_st.km1 = pwdata[7:0]; // [RULE7]
        OFS_DEVID:  next_st.did = pwdata[7:0]; // [RULE12]
        OFS_CFGSEL: begin
          next_st.laneSel = pwdata[SEL_LANE_LSB +: 4]; // [RULE17]
          next_st.octSel  = pwdata[SEL_OCT_LSB +: 4];
        end
        default: next_st.mode = st.mode;
      endcase
    end

    // Sync request from the receiver crosses in through two flops.
    next_st.syncMeta = syncReqN;
    next_st.syncLvl  = st.syncMeta;

    // Sampling configuration.
    next_st.des    = p.des; // [RULE5]
    // Only a single-channel mode with both inputs selected interleaves
    // across the two inputs. [RULE2]
    next_st.dualIn = p.des && (st.inSel == INSEL_BOTH);
    // Channel B samples on the opposite clock phase when interleaving,
    // giving twice the clock rate overall. [RULE1]
    next_st.chBInv  = p.des;
    next_st.rateFac = p.des ? 2'h2 : 2'h1; // [RULE1]
    if (p.des) begin
      next_st.inAEn = (st.inSel != INSEL_B); // [RULE1]
      next_st.inBEn = (st.inSel != INSEL_A); // [RULE1]
    end else begin
      next_st.inAEn = 1'b1;
      next_st.inBEn = 1'b1;
    end
    // Serializer and transport settings depend only on the mode and the scrambler bit, so
    // dual-input runs exactly like plain single-channel. [RULE3] [RULE6]
    next_st.rateX8 = p.rateX8;
    next_st.lanes  = p.lanes; // [RULE18]
    next_st.scrEn  = st.scr; // [RULE15]
    next_st.extMb  = p.enc64 ? EXTMB_VAL : 1'b0; // [RULE8]

    // Link sequencing.
    case (st.link)
      LINK_OFF: begin
        next_st.ilasCnt = 11'h000;
        if (st.linkEn && p.valid && kOk) begin
          next_st.link = LINK_CGS;
        end
      end
      LINK_CGS: begin
        next_st.ilasCnt = 11'h000;
        // Released sync ends code group sync; 64B/66B skips the
        // alignment sequence. [RULE19] [RULE9]
        if (st.syncLvl) begin
          next_st.link = p.enc64 ? LINK_DATA : LINK_ILAS;
        end
      end
      LINK_ILAS: begin
        next_st.ilasCnt = st.ilasCnt + 11'h001;
        if (!st.syncLvl) begin
          next_st.link = LINK_CGS; // [RULE19]
        end else if (st.ilasCnt == ilasLast) begin
          next_st.link = LINK_DATA; // [RULE9]
        end
      end
      LINK_DATA: begin
        if (!st.syncLvl) begin
          next_st.link = LINK_CGS; // [RULE19]
        end
      end
      default: next_st.link = LINK_OFF;
    endcase
    // Disable, bad mode or bad frame count drops the link.
    if (!st.linkEn || !p.valid || !kOk) begin
      next_st.link = LINK_OFF;
    end
    next_st.cgs  = (next_st.link == LINK_CGS); // [RULE19]
    next_st.ilas = (next_st.link == LINK_ILAS) && !p.enc64; // [RULE9]
    next_st.data = (next_st.link == LINK_DATA);
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st         <= '0;
      st.mode    <= RST_MODE;
      st.km1     <= RST_KM1;
      st.did     <= RST_DID;
      st.inSel   <= INSEL_A;
      st.syncMeta <= 1'b1;
      st.syncLvl <= 1'b1;
      st.link    <= LINK_OFF;
      st.inAEn   <= 1'b1;
      st.inBEn   <= 1'b1;
      st.rateFac <= 2'h1;
    end else begin
      st <= next_st;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign desMode          = st.des;
  assign dualInputMode    = st.dualIn;
  assign chBPhaseInverted = st.chBInv;
  assign analogInputAEn   = st.inAEn;
  assign analogInputBEn   = st.inBEn;
  assign sampleRateFactor = st.rateFac;
  assign laneRateX8       = st.rateX8;
  assign lanesPerLink     = st.lanes;
  assign scramblerEn      = st.scrEn;
  assign extMultiblocks   = st.extMb;
  assign sendCgs          = st.cgs;
  assign sendIlas         = st.ilas;
  assign sendData         = st.data;

endmodule

// ---- sim/jmp_rx_model.sv ----
// Purpose: Receiver side of the link: drives the sync request pin.
// Assumes: Sync request is active low and level sensitive.
// Notes:   The bench can force a loss of sync or a slow lock.
`timescale 1ns/100ps
module jmp_rx_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Transmitter link state
  input  wire logic sendCgs,
  input  wire logic sendIlas,
  input  wire logic sendData,
  // Bench control
  input  wire logic dropSync,
  input  wire logic slowRx,
  // Sync request pin
  output logic      syncReqN
);
  logic [4:0] cnt;

  // A receiver locks only after a run of code groups, not at once.
  always_ff @(posedge sys_clk) begin
    if (!nrst || dropSync || !(sendCgs || sendIlas || sendData)) begin
      cnt      <= 5'h00;
      syncReqN <= 1'b0;
    end else if (sendCgs && cnt != (slowRx ? 5'h0C : 5'h04)) begin
      cnt <= cnt + 5'h01;
    end else if (sendCgs) begin
      syncReqN <= 1'b1;
    end
  end
endmodule

// ---- sim/jmp_mode_ctrl_assertions.sv ----
// Purpose: Concurrent checks on the mode block's pins.
// Assumes: One clock; nrst is synchronous and active low.
// Notes:   Bound to every instance of the mode block.
`timescale 1ns/100ps
module jmp_mode_ctrl_chk (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Watched pins
  input wire logic       syncReqN,
  input wire logic       desMode,
  input wire logic       dualInputMode,
  input wire logic       chBPhaseInverted,
  input wire logic       analogInputAEn,
  input wire logic       analogInputBEn,
  input wire logic [1:0] sampleRateFactor,
  input wire logic       extMultiblocks,
  input wire logic       sendCgs,
  input wire logic       sendIlas,
  input wire logic       sendData
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_phase;
    chBPhaseInverted == desMode;
  endproperty
  a_phase: assert property (p_phase)
    else $error("B phase not tied to des mode");
  property p_rate;
    sampleRateFactor == (desMode ? 2'h2 : 2'h1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("sample rate factor wrong");
  property p_dual;
    dualInputMode |-> desMode && analogInputAEn && analogInputBEn;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual input without its conditions");
  property p_ext;
    !extMultiblocks;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended multiblock flag set");
  property p_state;
    $onehot0({sendCgs, sendIlas, sendData});
  endproperty
  a_state: assert property (p_state)
    else $error("two link states at once");
  property p_ilas;
    $rose(sendIlas) |-> $past(sendCgs) && $past(syncReqN, 3);
  endproperty
  a_ilas: assert property (p_ilas)
    else $error("alignment began without sync release");
  property p_data;
    $rose(sendData) |-> $past(sendIlas);
  endproperty
  a_data: assert property (p_data)
    else $error("data began without alignment");
  property p_resync;
    (!syncReqN) [*4] |-> !sendIlas && !sendData;
  endproperty
  a_resync: assert property (p_resync)
    else $error("sync request ignored");
endmodule

bind jmp_mode_ctrl jmp_mode_ctrl_chk i_chk (.sys_clk, .nrst, .syncReqN,
  .desMode, .dualInputMode, .chBPhaseInverted, .analogInputAEn,
  .analogInputBEn, .sampleRateFactor, .extMultiblocks, .sendCgs,
  .sendIlas, .sendData);

// ---- sim/jmp_mode_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the link mode block.
// Assumes: APB slave answers by pready; receiver model drives sync.
// Notes:   Each scenario is a task of its own.
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module jmp_mode_ctrl_tb_top
  import jmp_pkg::*;
;
  localparam logic [31:0] P0 =
    {2'h2, 1'h1, 2'h2, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 2'h0, 4'h0};
  int          compares;
  int          miscompares;
  logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        syncReqN, dropSync, slowRx, lastErr, scramblerEn;
  logic        desMode, dualInputMode, chBPhaseInverted, extMultiblocks;
  logic        analogInputAEn, analogInputBEn, sendCgs, sendIlas, sendData;
  logic [1:0]  sampleRateFactor;
  logic [3:0]  lanesPerLink;
  logic [7:0]  paddr, laneRateX8;
  logic [31:0] pwdata, prdata;

  jmp_mode_ctrl i_dut (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .syncReqN, .desMode,
    .dualInputMode, .chBPhaseInverted, .analogInputAEn, .analogInputBEn,
    .sampleRateFactor, .laneRateX8, .lanesPerLink, .scramblerEn,
    .extMultiblocks, .sendCgs, .sendIlas, .sendData);
  jmp_rx_model i_rx (.sys_clk, .nrst, .sendCgs, .sendIlas, .sendData,
    .dropSync, .slowRx, .syncReqN);

  always #12.5 sys_clk = ~sys_clk;

  // ----------------
  // Bus tasks
  // ----------------
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    // The idle edge first keeps psel from being cleared and set at once.
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(a, 1'b0, 32'h0, r);
  endtask
  function automatic logic [31:0] ctl(logic [4:0] m, logic [1:0] s,
                                      logic c, logic e);
    return {23'h0, e, s, c, m};
  endfunction

  // ----------------
  // Scenarios
  // ----------------
  task automatic tReset();
    logic [31:0] r;
    rd(OFS_KCOUNT, r);
    `CHK("kcount", 32'h1F, r)
    `CHK("des", 1'b1, desMode)
    rd(OFS_STATUS, r);
    `CHK("k", 9'h020, r[31:23])
    wr(OFS_PARAMS, 32'hFFFFFFFF);
    rd(OFS_PARAMS, r);
    `CHK("params ro", P0, r)
    rd(8'h18, r);
    `CHK("unmapped", 33'h100000000, {lastErr, r})
    wr(OFS_CTRL, ctl(5'h04, INSEL_A, 1'b0, 1'b0));
    rd(OFS_PARAMS, r);
    `CHK("reserved", 32'h0, r)
  endtask
  task automatic tMode(input logic [4:0] m, input logic [7:0] r8,
                       input logic d, input logic [3:0] l, mm, f, s,
                       input logic [4:0] n, input logic [1:0] c);
    logic [31:0] r;
    wr(OFS_CTRL, ctl(m, INSEL_A, 1'b0, 1'b0));
    rd(OFS_PARAMS, r);
    `CHK("params", {2'h2, d, 2'h2, l, mm, f, s, n, c, 4'h0}, r)
    `CHK("des", d, desMode)
    `CHK("rate", d ? 2'h2 : 2'h1, sampleRateFactor)
    `CHK("lane rate", r8, laneRateX8)
    `CHK("lanes", l, lanesPerLink)
  endtask
  task automatic tDual();
    logic [31:0] r;
    wr(OFS_CTRL, ctl(5'h00, INSEL_BOTH, 1'b0, 1'b0));
    rd(OFS_PARAMS, r);
    `CHK("dual params", P0, r)
    `CHK("dual", 1'b1, dualInputMode)
    `CHK("b phase", 1'b1, chBPhaseInverted)
    `CHK("b input", 1'b1, analogInputBEn)
    `CHK("a input", 1'b1, analogInputAEn)
    wr(OFS_CTRL, ctl(5'h02, INSEL_BOTH, 1'b0, 1'b0));
    rd(OFS_PARAMS, r);
    `CHK("dual off", 1'b0, dualInputMode)
  endtask
  task automatic tIlas();
    logic [31:0] r;
    logic [7:0]  lid;
    logic [7:0]  ck;
    logic [7:0]  ex [14];
    wr(OFS_CTRL, ctl(5'h0A, INSEL_A, 1'b1, 1'b0));
    wr(OFS_KCOUNT, 32'h0F);
    wr(OFS_DEVID, 32'hA5);
    for (int i = 0; i < 2; i++) begin
      lid = i ? 8'h05 : 8'h03;
      ck = 8'hA5 + 8'h32 + lid;
      ex = '{8'hA5, 8'h00, lid, 8'h81, 8'h01, 8'h0F, 8'h01, 8'h0E,
             8'h2F, 8'h20, 8'h00, 8'h00, 8'h00, ck};
      for (int o = 0; o < 14; o++) begin
        wr(OFS_CFGSEL, {24'h0, 4'(o), lid[3:0]});
        rd(OFS_STATUS, r);
        `CHK("octet", ex[o], r[7:0])
        `CHK("sum", ck, r[15:8])
      end
    end
    `CHK("k", 9'h010, r[31:23])
    wr(OFS_CTRL, ctl(5'h13, INSEL_A, 1'b0, 1'b0));
    wr(OFS_CFGSEL, 32'hA0);
    rd(OFS_STATUS, r);
    `CHK("hd octet", 8'h00, r[7:0])
  endtask
  task automatic tLink();
    int n;
    n = 0;
    wr(OFS_KCOUNT, 32'h04);
    wr(OFS_CTRL, ctl(5'h00, INSEL_A, 1'b1, 1'b1));
    repeat (4) @(posedge sys_clk);
    `CHK("bad k", 1'b0, sendCgs)
    wr(OFS_KCOUNT, 32'h03);
    while (sendIlas !== 1'b1) @(posedge sys_clk);
    `CHK("scrambler", 1'b1, scramblerEn)
    `CHK("ext mb", 1'b0, extMultiblocks)
    while (sendIlas === 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("ilas len", 16, n)
    `CHK("data", 1'b1, sendData)
    slowRx <= 1'b1;
    dropSync <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("resync", 1'b1, sendCgs)
    dropSync <= 1'b0;
    while (sendData !== 1'b1) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    {sys_clk, nrst, psel, penable, pwrite, dropSync, slowRx} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    compares = 0;
    miscompares = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    tReset();
    tMode(5'h00, 8'h20, 1'h1, 4'h4, 4'h4, 4'h8, 4'h5, 5'h0C, 2'h0);
    tMode(5'h07, 8'h14, 1'h0, 4'h4, 4'h1, 4'h1, 4'h4, 5'h08, 2'h0);
    tMode(5'h0A, 8'h28, 1'h0, 4'h2, 4'h2, 4'h2, 4'h1, 5'h0F, 2'h1);
    tMode(5'h10, 8'h05, 1'h0, 4'h8, 4'h2, 4'h2, 4'h4, 5'h0F, 2'h1);
    tMode(5'h19, 8'h0A, 1'h1, 4'h8, 4'h1, 4'h2, 4'h8, 5'h0F, 2'h1);
    tDual();
    tIlas();
    tLink();
    print_verdict();
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
endmodule
